// *** bench/extended_addressing_scope_unit_tb_top.sv ***
/*
 Self-checking bench for the scope unit: scope openers, retire counts, traps,
 overridden addresses and the memory map, checked against a reference model.
 Assumes the pipeline model and the design package are compiled first.
*/
module extended_addressing_scope_unit_tb_top;
   import ext_scope_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   logic core_clk, rst, rom_enable, rom_seg1, class_b_trap, mem_req, short_req;
   logic short_is_bitoff;
   logic [15:0] gpr_value, mem_addr;
   logic [9:0] data_page_pointer;
   logic [7:0] short_addr;
   logic instr_valid, instr_retire, scope_decoded, interrupt_lock, class_a_trap_lock;
   logic [7:0] instr_byte0, instr_byte1, instr_byte2, instr_byte3;
   logic [2:0] instr_length, e_cnt;
   logic scope_active, reg_extended, phys_valid_reg, short_valid_reg, rom_hit, ram_hit;
   logic xfer_ptr_hit, ext_reg_hit, ext_reg_bit_hit, std_reg_hit, reserved_hit;
   logic internal_hit, external_access, e_reg, e_pg, e_seg, rw;
   logic [23:0] phys_addr_reg, p;
   logic [15:0] short_phys_reg;
   logic [12:0] rom_offset;
   logic [9:0] e_op1;
   logic [23:0] pq[$];
   logic [15:0] sq[$];
   logic [23:0] tbl[23] = '{24'h000000, 24'h001fff, 24'h002005, 24'h007fff, 24'h008000,
      24'h010000, 24'h013abc, 24'h017fff, 24'h018000, 24'h00f000, 24'h00f0ff, 24'h00f100,
      24'h00f1ff, 24'h00f200, 24'h00f5ff, 24'h00f600, 24'h00fcdf, 24'h00fce0, 24'h00fcff,
      24'h00fdff, 24'h00fe00, 24'h00ffff, 24'h0ff000};
   int n_errors = 0;
   int samples_checked = 0;
   int f, k;
   logic [2:0] cnt;
   logic quiet;

   extended_addressing_scope_unit uut (.core_clk, .rst, .rom_enable, .rom_seg1,
      .instr_valid, .instr_byte0, .instr_byte1, .instr_byte2, .instr_byte3, .gpr_value,
      .instr_retire, .class_b_trap, .scope_decoded, .instr_length, .interrupt_lock,
      .class_a_trap_lock, .scope_active, .reg_extended, .mem_req, .mem_addr, .data_page_pointer,
      .phys_valid_reg, .phys_addr_reg, .short_req, .short_addr, .short_is_bitoff,
      .short_valid_reg, .short_phys_reg, .rom_hit, .rom_offset, .ram_hit, .xfer_ptr_hit,
      .ext_reg_hit, .ext_reg_bit_hit, .std_reg_hit, .reserved_hit, .internal_hit,
      .external_access);

   scope_pipe_model pm (.core_clk, .instr_valid, .instr_byte0, .instr_byte1, .instr_byte2,
      .instr_byte3, .instr_retire);

   // ***********************************************
   // Reference model
   // ***********************************************
   function automatic logic dec(input logic [7:0] a, input logic [7:0] b);
      return a == OP_IMM_FORM || a == OP_REG_FORM || (a == OP_REG_ONLY && b[7:6] == SUB_SEG_REG);
   endfunction

   wire e_act = e_cnt != 3'h0;
   wire e_dec = instr_valid && dec(instr_byte0, instr_byte1);

   always @(posedge core_clk) begin
      if (rst || class_b_trap) begin
         e_cnt <= 3'h0;
      end else if (instr_retire && e_dec) begin
         e_cnt <= {1'b0, instr_byte1[5:4]} + 3'h1;
         e_reg <= instr_byte0 == OP_REG_ONLY || instr_byte1[7];
         e_pg <= instr_byte0 != OP_REG_ONLY && instr_byte1[6];
         e_seg <= instr_byte0 != OP_REG_ONLY && !instr_byte1[6];
         e_op1 <= instr_byte0 == OP_IMM_FORM ? {instr_byte3[1:0], instr_byte2} : gpr_value[9:0];
      end else if (instr_retire && e_act) begin
         e_cnt <= e_cnt - 3'h1;
      end
   end

   function automatic logic [23:0] phys(input logic [15:0] a);
      if (e_act && e_pg) return {e_op1, a[13:0]};
      if (e_act && e_seg) return {e_op1[7:0], a};
      return {data_page_pointer, a[13:0]};
   endfunction

   function automatic logic [15:0] sphys(input logic [7:0] a, input logic bo);
      logic x;
      x = e_act && e_reg;
      if (!bo) return (x ? EXT_WORD_BASE : STD_WORD_BASE) + {7'h0, a, 1'b0};
      if (!a[7]) return RAM_BIT_BASE + {7'h0, a, 1'b0};
      return (x ? EXT_BIT_BASE : STD_BIT_BASE) + {8'h0, a[6:0], 1'b0};
   endfunction

   task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   // ***********************************************
   // Stimulus for the address paths
   // ***********************************************
   // Boundary addresses picked at random every cycle, under any scope state
   always @(posedge core_clk) begin
      k = $urandom_range(0, 22);
      mem_req <= !rst && !quiet && $urandom_range(0, 1);
      short_req <= !rst && !quiet && $urandom_range(0, 1);
      data_page_pointer <= tbl[k][23:14];
      mem_addr <= {2'($urandom), tbl[k][13:0]};
      short_addr <= 8'($urandom);
      short_is_bitoff <= 1'($urandom);
   end

   // ***********************************************
   // Watcher: state, locks, results against notes
   // ***********************************************
   always @(negedge core_clk) begin
      if (!rst) begin
         chk("decoded", e_dec, scope_decoded);
         if (e_dec) chk("length", instr_byte0 == OP_IMM_FORM ? 4 : 2, instr_length);
         chk("active", e_act, scope_active);
         chk("reg_ext", e_act && e_reg, reg_extended);
         chk("int_lock", e_act || e_dec, interrupt_lock);
         chk("trap_lock", e_act || e_dec, class_a_trap_lock);
         if (phys_valid_reg) begin
            p = pq.size() ? pq.pop_front() : 24'hxxxxxx;
            rw = rom_enable && p[23:15] == (rom_seg1 ? ROM_WIN_SEG1 : ROM_WIN_SEG0);
            chk("phys", p, phys_addr_reg);
            chk("rom", rw, rom_hit);
            if (rw) chk("rom_ofs", p[12:0], rom_offset);
            chk("ram", p inside {[RAM_LO:RAM_HI]}, ram_hit);
            chk("ptr", p inside {[XFER_PTR_LO:XFER_PTR_HI]}, xfer_ptr_hit);
            chk("ext", p inside {[EXT_LO:EXT_HI]}, ext_reg_hit);
            chk("ext_bit", p inside {[EXT_BIT_LO:EXT_HI]}, ext_reg_bit_hit);
            chk("std", p inside {[STD_LO:STD_HI]}, std_reg_hit);
            chk("rsv", p inside {[RSV_LO:RSV_HI]}, reserved_hit);
            chk("internal", rw || p[23:12] == 12'h00f, internal_hit);
            chk("external", !(rw || p[23:12] == 12'h00f), external_access);
         end
         if (short_valid_reg) begin
            p = sq.size() ? {8'h00, sq.pop_front()} : 24'hxxxxxx;
            chk("short", p, short_phys_reg);
         end
         if (mem_req) pq.push_back(phys(mem_addr));
         if (short_req) sq.push_back(sphys(short_addr, short_is_bitoff));
      end
   end

   // ***********************************************
   // Main sequence
   // ***********************************************
   function automatic logic [31:0] opener(input int f, input logic [2:0] c);
      logic [9:0] r;
      logic [1:0] s;
      r = 10'($urandom);
      s = f == 8 ? SUB_SEG_REG : 2'(f);
      return {f < 4 ? OP_IMM_FORM : f < 8 ? OP_REG_FORM : OP_REG_ONLY, s, c[1:0] - 2'h1,
         4'h0, r[7:0], 6'h0, s[0] ? r[9:8] : 2'h0};
   endfunction

   task automatic wrap_up;
      chk("pending", 0, pq.size() + sq.size());
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   initial begin
      repeat (100000) @(posedge core_clk);
      n_errors++;
      wrap_up;
   end

   initial begin
      rst = 1'b1;
      rom_enable = 1'b1;
      rom_seg1 = 1'b0;
      class_b_trap = 1'b0;
      gpr_value = 16'h0;
      quiet = 1'b0;
      void'($urandom(32'haf80));
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      for (int g = 0; g < 3; g++) begin
         rom_enable <= g != 2;
         rom_seg1 <= g == 1;
         pm.idle(2);
         for (f = 0; f < 18; f++) begin
            cnt = 3'($urandom_range(1, 4));
            gpr_value <= 16'($urandom);
            pm.exec(opener(f / 2, cnt), 1);
            // Back to back with multi-cycle ones mixed in, one past the end
            repeat (cnt + 1) pm.exec(32'h0, $urandom_range(1, 3));
            pm.idle(2);
         end
      end
      // A trap in mid-scope cancels it; an opener retiring with a trap is dropped
      pm.exec(opener(1, 3'h4), 1);
      class_b_trap <= 1'b1;
      pm.exec(32'h0, 2);
      pm.exec(opener(6, 3'h2), 1);
      class_b_trap <= 1'b0;
      pm.exec(32'h0, 1);
      // Reload from a second opener inside a live scope
      pm.exec(opener(3, 3'h4), 1);
      pm.exec(opener(4, 3'h1), 1);
      repeat (2) pm.exec(32'h0, 1);
      // Requests stop first so no note is still in flight at the final count
      quiet <= 1'b1;
      pm.idle(3);
      wrap_up;
   end
endmodule // extended_addressing_scope_unit_tb_top

// *** bench/scope_pipe_model.sv ***
/*
 Behavioural model of the CPU pipeline that feeds the scope unit: shows one
 instruction at a time and pulses retire once at its last cycle.
 Assumes its tasks are called just after a rising edge of core_clk.
*/
module scope_pipe_model (
   input wire logic core_clk,
   output logic instr_valid,
   output logic [7:0] instr_byte0,
   output logic [7:0] instr_byte1,
   output logic [7:0] instr_byte2,
   output logic [7:0] instr_byte3,
   output logic instr_retire
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      instr_valid = 1'b0;
      instr_retire = 1'b0;
      {instr_byte0, instr_byte1, instr_byte2, instr_byte3} = 32'h0;
   end

   // Holds the bytes for hold cycles; the last one retires it as a single unit
   task automatic exec(input logic [31:0] ins, input int hold);
      int i;
      instr_valid <= 1'b1;
      {instr_byte0, instr_byte1, instr_byte2, instr_byte3} <= ins;
      instr_retire <= (hold == 1);
      for (i = 1; i < hold; i++) begin
         @(posedge core_clk);
         instr_retire <= (i == hold - 1);
      end
      @(posedge core_clk);
   endtask

   // Stale bytes are inverted so nothing can lean on the last instruction
   task automatic idle(input int n);
      instr_valid <= 1'b0;
      instr_retire <= 1'b0;
      {instr_byte0, instr_byte1, instr_byte2, instr_byte3} <=
         ~{instr_byte0, instr_byte1, instr_byte2, instr_byte3};
      repeat (n) @(posedge core_clk);
   endtask
endmodule // scope_pipe_model

// *** verilog/ext_scope_pkg.sv ***
/*
 Constants, encodings and address map for the extended addressing scope unit.
 Assumes the CPU pipeline presents whole instructions, one retire pulse each.
*/
// What this block does
// - Counter loaded from operand, covers 1-4 instructions
// - Scope locks interrupts and class A traps
// - Override applies to the very next instruction
// - One decrement per executed instruction, however long
// - Class B trap cancels scope and unlocks
// - Completion: zero count, pointer pages, unlock
// - Segment scope: operand gives bits 23..16
// - Register scopes send short accesses to extended space
// - Page-register scope: D7 sub 11 four bytes, DC two
// - Segment sub 00, segment-register sub 10
// - 8K ROM in segment 0 or segment 1
// - Whole 32K ROM window internal, no external
// - ROM aliases every 8K across window
// - 2K internal RAM at 00F600h..00FDFFh
// - Event transfer pointers at 0FCE0h..0FCFFh
// - Extended registers 00F000h..00F1FFh, two sections
// - Full 16-bit addresses reach both spaces directly
// - Short modes use normal base outside scopes
// - Both register spaces reachable at once
// - Page scope: operand gives 10-bit page 23..14
// - Page-register scope combines both overrides
package ext_scope_pkg;
   // ***********************************************
   // Instruction encodings
   // ***********************************************
   localparam logic [7:0] OP_REG_FORM = 8'hdc;
   localparam logic [7:0] OP_IMM_FORM = 8'hd7;
   localparam logic [7:0] OP_REG_ONLY = 8'hd1;
   localparam logic [1:0] SUB_SEG = 2'h0;
   localparam logic [1:0] SUB_PAGE = 2'h1;
   localparam logic [1:0] SUB_SEG_REG = 2'h2;
   localparam logic [1:0] SUB_PAGE_REG = 2'h3;
   localparam int SUB_MSB = 7;
   localparam int SUB_LSB = 6;
   localparam int CNT_MSB = 5;
   localparam int CNT_LSB = 4;
   localparam logic [2:0] LEN_REG_FORM = 3'h2;
   localparam logic [2:0] LEN_IMM_FORM = 3'h4;
   localparam logic [2:0] COUNT_RESET = 3'h0;

   typedef enum logic [2:0] {
      SCOPE_IDLE, SCOPE_PAGE, SCOPE_SEG, SCOPE_REG, SCOPE_PAGE_REG, SCOPE_SEG_REG
   } scope_t;

   // ***********************************************
   // Address map
   // ***********************************************
   localparam logic [8:0] ROM_WIN_SEG0 = 9'h000;
   localparam logic [8:0] ROM_WIN_SEG1 = 9'h002;
   localparam int ROM_OFS_BITS = 13;
   localparam logic [11:0] INT_AREA_TOP = 12'h00f;
   localparam logic [23:0] RAM_LO = 24'h00f600;
   localparam logic [23:0] RAM_HI = 24'h00fdff;
   localparam logic [23:0] XFER_PTR_LO = 24'h00fce0;
   localparam logic [23:0] XFER_PTR_HI = 24'h00fcff;
   localparam logic [23:0] EXT_LO = 24'h00f000;
   localparam logic [23:0] EXT_BIT_LO = 24'h00f100;
   localparam logic [23:0] EXT_HI = 24'h00f1ff;
   localparam logic [23:0] RSV_LO = 24'h00f200;
   localparam logic [23:0] RSV_HI = 24'h00f5ff;
   localparam logic [23:0] STD_LO = 24'h00fe00;
   localparam logic [23:0] STD_HI = 24'h00ffff;
   localparam logic [15:0] STD_WORD_BASE = 16'hfe00;
   localparam logic [15:0] STD_BIT_BASE = 16'hff00;
   localparam logic [15:0] EXT_WORD_BASE = 16'hf000;
   localparam logic [15:0] EXT_BIT_BASE = 16'hf100;
   localparam logic [15:0] RAM_BIT_BASE = 16'hfd00;
endpackage

// *** verilog/extended_addressing_scope_unit.sv ***
/*
 Scope instruction decoder, override state and address formation for the
 extended page, segment and register scopes, plus the memory map decode.
 Assumes the pipeline shows the decoded instruction bytes with instr_valid
 and pulses instr_retire once as each instruction completes, and that the
 register form's operand register value arrives on gpr_value.
*/
module extended_addressing_scope_unit
   import ext_scope_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic rom_enable,
   input wire logic rom_seg1,
   input wire logic instr_valid,
   input wire logic [7:0] instr_byte0,
   input wire logic [7:0] instr_byte1,
   input wire logic [7:0] instr_byte2,
   input wire logic [7:0] instr_byte3,
   input wire logic [15:0] gpr_value,
   input wire logic instr_retire,
   input wire logic class_b_trap,
   output logic scope_decoded,
   output logic [2:0] instr_length,
   output logic interrupt_lock,
   output logic class_a_trap_lock,
   output logic scope_active,
   output logic reg_extended,
   input wire logic mem_req,
   input wire logic [15:0] mem_addr,
   input wire logic [9:0] data_page_pointer,
   output logic phys_valid_reg,
   output logic [23:0] phys_addr_reg,
   input wire logic short_req,
   input wire logic [7:0] short_addr,
   input wire logic short_is_bitoff,
   output logic short_valid_reg,
   output logic [15:0] short_phys_reg,
   output logic rom_hit,
   output logic [12:0] rom_offset,
   output logic ram_hit,
   output logic xfer_ptr_hit,
   output logic ext_reg_hit,
   output logic ext_reg_bit_hit,
   output logic std_reg_hit,
   output logic reserved_hit,
   output logic internal_hit,
   output logic external_access
);
   // ***********************************************
   // Instruction decode
   // ***********************************************
   logic [1:0] sub_op;
   logic [2:0] op_count;
   logic is_reg_form;
   logic is_imm_form;
   logic is_reg_only;
   scope_t dec_kind;
   logic [9:0] dec_value;

   always_comb begin
      sub_op = instr_byte1[SUB_MSB:SUB_LSB];
      // Count field holds the operand minus one, so 1..4 always results
      op_count = {1'b0, instr_byte1[CNT_MSB:CNT_LSB]} + 3'h1;
      is_reg_form = instr_byte0 == OP_REG_FORM;
      is_imm_form = instr_byte0 == OP_IMM_FORM;
      is_reg_only = instr_byte0 == OP_REG_ONLY && sub_op == SUB_SEG_REG;
      dec_kind = SCOPE_IDLE;
      if (is_reg_only) begin
         dec_kind = SCOPE_REG;
      end else if (is_reg_form || is_imm_form) begin
         case (sub_op)
            SUB_SEG: dec_kind = SCOPE_SEG;
            SUB_PAGE: dec_kind = SCOPE_PAGE;
            SUB_SEG_REG: dec_kind = SCOPE_SEG_REG;
            default: dec_kind = SCOPE_PAGE_REG;
         endcase
      end
      // Immediate page is split over bytes 2 and 3, segment is byte 2
      if (is_reg_form) begin
         dec_value = gpr_value[9:0];
      end else if (sub_op == SUB_PAGE || sub_op == SUB_PAGE_REG) begin
         dec_value = {instr_byte3[1:0], instr_byte2};
      end else begin
         dec_value = {2'h0, instr_byte2};
      end
      scope_decoded = instr_valid && dec_kind != SCOPE_IDLE;
      if (is_imm_form) begin
         instr_length = LEN_IMM_FORM;
      end else begin
         instr_length = LEN_REG_FORM;
      end
   end

   // ***********************************************
   // Scope state
   // ***********************************************
   logic open_now;
   logic count_active;
   logic [2:0] count_reg;
   scope_t kind_reg;
   scope_t kind_next;
   logic [9:0] value_reg;
   logic [9:0] value_next;

   // Scope starts when the opening instruction retires; trap wins
   assign open_now = scope_decoded && instr_retire && !class_b_trap;

   scope_counter counter_u (
      .core_clk(core_clk),
      .rst(rst),
      .load(open_now),
      .load_count(op_count),
      .step(instr_retire),
      .cancel(class_b_trap),
      .count_reg(count_reg),
      .active(count_active)
   );

   always_comb begin
      kind_next = kind_reg;
      value_next = value_reg;
      if (class_b_trap) begin
         kind_next = SCOPE_IDLE;
      end else if (open_now) begin
         kind_next = dec_kind;
         value_next = dec_value;
      end else if (instr_retire && count_reg == 3'h1) begin
         kind_next = SCOPE_IDLE;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         kind_reg <= SCOPE_IDLE;
         value_reg <= 10'h000;
      end else begin
         kind_reg <= kind_next;
         value_reg <= value_next;
      end
   end

   // Override flags are live from the cycle after the opener retires
   logic page_ovr;
   logic seg_ovr;

   always_comb begin
      scope_active = count_active;
      page_ovr = count_active && (kind_reg == SCOPE_PAGE || kind_reg == SCOPE_PAGE_REG);
      seg_ovr = count_active && (kind_reg == SCOPE_SEG || kind_reg == SCOPE_SEG_REG);
      reg_extended = count_active && (kind_reg == SCOPE_REG || kind_reg == SCOPE_PAGE_REG
         || kind_reg == SCOPE_SEG_REG);
      // Lock also covers the opener itself so nothing slips in between
      interrupt_lock = count_active || scope_decoded;
      class_a_trap_lock = count_active || scope_decoded;
   end

   // ***********************************************
   // Address formation
   // ***********************************************
   logic [23:0] phys_next;
   logic [15:0] short_next;
   logic [15:0] short_word;

   always_comb begin
      if (seg_ovr) begin
         phys_next = {value_reg[7:0], mem_addr};
      end else if (page_ovr) begin
         phys_next = {value_reg, mem_addr[13:0]};
      end else begin
         phys_next = {data_page_pointer, mem_addr[13:0]};
      end
      short_word = {7'h00, short_addr, 1'b0};
      if (short_is_bitoff && !short_addr[7]) begin
         // Lower bit offsets always point at internal RAM
         short_next = RAM_BIT_BASE + short_word;
      end else if (short_is_bitoff) begin
         short_next = (reg_extended ? EXT_BIT_BASE : STD_BIT_BASE)
            + {8'h00, short_addr[6:0], 1'b0};
      end else begin
         short_next = (reg_extended ? EXT_WORD_BASE : STD_WORD_BASE)
            + short_word;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         phys_valid_reg <= 1'b0;
         phys_addr_reg <= 24'h000000;
         short_valid_reg <= 1'b0;
         short_phys_reg <= 16'h0000;
      end else begin
         phys_valid_reg <= mem_req;
         short_valid_reg <= short_req;
         if (mem_req) begin
            phys_addr_reg <= phys_next;
         end
         if (short_req) begin
            short_phys_reg <= short_next;
         end
      end
   end

   // ***********************************************
   // Memory map
   // ***********************************************
   memory_map_decoder map_u (
      .addr(phys_addr_reg),
      .rom_enable(rom_enable),
      .rom_seg1(rom_seg1),
      .rom_hit(rom_hit),
      .rom_offset(rom_offset),
      .ram_hit(ram_hit),
      .xfer_ptr_hit(xfer_ptr_hit),
      .ext_reg_hit(ext_reg_hit),
      .ext_reg_bit_hit(ext_reg_bit_hit),
      .std_reg_hit(std_reg_hit),
      .reserved_hit(reserved_hit),
      .internal_hit(internal_hit)
   );

   assign external_access = phys_valid_reg && !internal_hit;

   // ***********************************************
   // Checks
   // ***********************************************
   default clocking chk_cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   sequence open_s;
      open_now;
   endsequence

   sequence quiet_retire_s;
      instr_retire && !class_b_trap && !scope_decoded;
   endsequence

   scope_next_a: assert property (open_s |=> scope_active)
      else $error("scope not active on next instruction");

   scope_one_a: assert property (
      (open_s and (op_count == 3'h1)) ##1 quiet_retire_s |=> !scope_active)
      else $error("single-instruction scope overran");

   lock_drop_a: assert property (
      (quiet_retire_s and (count_reg == 3'h1)) |=> !interrupt_lock || scope_decoded)
      else $error("lock held after scope end");

   reg_open_a: assert property (
      (open_s and (instr_byte1[7] == 1'b1)) |=> reg_extended)
      else $error("register scope not redirecting");

   scope_lock_a: assert property (
      scope_active |-> interrupt_lock && class_a_trap_lock)
      else $error("lock missing inside scope");

   trap_cancel_a: assert property (
      class_b_trap |=> !scope_active && (!interrupt_lock || scope_decoded))
      else $error("class B trap did not end scope");

   seg_addr_a: assert property (
      mem_req && seg_ovr |=> phys_addr_reg == {$past(value_reg[7:0]), $past(mem_addr)})
      else $error("segment override address wrong");

   page_addr_a: assert property (
      mem_req && page_ovr |=> phys_addr_reg[23:14] == $past(value_reg))
      else $error("page override address wrong");

   ptr_page_a: assert property (
      mem_req && !seg_ovr && !page_ovr |=> phys_addr_reg[23:14] == $past(data_page_pointer))
      else $error("data page pointer not used outside scope");

   short_std_a: assert property (
      short_req && !short_is_bitoff && !reg_extended |=>
         short_phys_reg[15:9] == STD_WORD_BASE[15:9])
      else $error("short access left normal space");

   short_ext_a: assert property (
      short_req && !short_is_bitoff && reg_extended |=>
         short_phys_reg[15:9] == EXT_WORD_BASE[15:9])
      else $error("short access not redirected");

   bit_ext_a: assert property (
      short_req && short_is_bitoff && short_addr[7] && reg_extended |=>
         short_phys_reg[15:8] == EXT_BIT_BASE[15:8])
      else $error("bit access not redirected");

   bit_std_a: assert property (
      short_req && short_is_bitoff && short_addr[7] && !reg_extended |=>
         short_phys_reg[15:8] == STD_BIT_BASE[15:8])
      else $error("bit access left normal space");

   len_imm_a: assert property (
      scope_decoded && instr_byte0 == OP_IMM_FORM |-> instr_length == LEN_IMM_FORM)
      else $error("immediate form length wrong");

   rom_win_a: assert property (
      phys_valid_reg && rom_enable && !rom_seg1 && phys_addr_reg < 24'h008000
      |-> rom_hit && !external_access)
      else $error("ROM window produced external access");

   ram_map_a: assert property (
      phys_valid_reg && phys_addr_reg == RAM_LO |-> ram_hit && !external_access)
      else $error("RAM base not decoded");

   ext_map_a: assert property (
      phys_valid_reg && phys_addr_reg[23:9] == EXT_LO[23:9]
      |-> ext_reg_hit && !std_reg_hit && !external_access)
      else $error("extended register space not decoded");

   ptr_map_a: assert property (
      phys_valid_reg && phys_addr_reg[23:5] == XFER_PTR_LO[23:5] |-> xfer_ptr_hit && ram_hit)
      else $error("transfer pointer area not decoded");
endmodule // extended_addressing_scope_unit

// *** verilog/memory_map_decoder.sv ***
/*
 On-chip memory map decoder for one 24-bit physical address.
 Assumes rom_enable and rom_seg1 stay static while addresses are decoded.
*/
module memory_map_decoder
   import ext_scope_pkg::*;
(
   input wire logic [23:0] addr,
   input wire logic rom_enable,
   input wire logic rom_seg1,
   output logic rom_hit,
   output logic [12:0] rom_offset,
   output logic ram_hit,
   output logic xfer_ptr_hit,
   output logic ext_reg_hit,
   output logic ext_reg_bit_hit,
   output logic std_reg_hit,
   output logic reserved_hit,
   output logic internal_hit
);
   logic [8:0] win_sel;

   always_comb begin
      win_sel = rom_seg1 ? ROM_WIN_SEG1 : ROM_WIN_SEG0;
      // 32K window is claimed even though only 8K is populated
      rom_hit = rom_enable && addr[23:15] == win_sel;
      rom_offset = addr[ROM_OFS_BITS-1:0];
      ram_hit = addr >= RAM_LO && addr <= RAM_HI;
      xfer_ptr_hit = addr >= XFER_PTR_LO && addr <= XFER_PTR_HI;
      // Full addresses reach either register space, no scope involved
      ext_reg_hit = addr >= EXT_LO && addr <= EXT_HI;
      ext_reg_bit_hit = addr >= EXT_BIT_LO && addr <= EXT_HI;
      std_reg_hit = addr >= STD_LO && addr <= STD_HI;
      reserved_hit = addr >= RSV_LO && addr <= RSV_HI;
      internal_hit = rom_hit || addr[23:12] == INT_AREA_TOP;
   end
endmodule // memory_map_decoder

// *** verilog/scope_counter.sv ***
/*
 Scope length counter: load, per-instruction step, trap cancel.
 Assumes one step pulse per executed instruction from the pipeline.
*/
module scope_counter
   import ext_scope_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [2:0] load_count,
   input wire logic step,
   input wire logic cancel,
   output logic [2:0] count_reg,
   output logic active
);
   logic [2:0] count_next;

   always_comb begin
      count_next = count_reg;
      if (cancel) begin
         count_next = COUNT_RESET;
      end else if (load) begin
         count_next = load_count;
      end else if (step && count_reg != COUNT_RESET) begin
         count_next = count_reg - 3'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         count_reg <= COUNT_RESET;
      end else begin
         count_reg <= count_next;
      end
   end

   assign active = count_reg != COUNT_RESET;

   sequence loaded_s;
      load && !cancel;
   endsequence

   property load_prop;
      @(posedge core_clk) disable iff (rst) loaded_s |=> count_reg == $past(load_count);
   endproperty
   count_load_a: assert property (load_prop)
      else $error("count not loaded from operand");

   count_step_a: assert property (@(posedge core_clk) disable iff (rst)
      step && !load && !cancel && active |=> count_reg == $past(count_reg) - 3'h1)
      else $error("count did not step by one");

   count_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      !step && !load && !cancel |=> $stable(count_reg))
      else $error("count moved without an instruction");
endmodule // scope_counter
